/* hw/acl_rule_filter.sv */
// Purpose: Ingress rule engine: table, group arbitration, action, rule timers
// Assumes: Frame fields and byte register strobes come from core-clock logic
// Notes:   Result appears one cycle after frame_valid
//
// What this block does
// R1: Kind 00 disables a rule; 01 Layer 2, 10 Layer 3, 11 Layer 4.
// R2: Layer 2 select 00 takes an 11-bit count from the action fields.
// R3: Top port map bit picks count unit: 0 microseconds, 1 milliseconds.
// R4: Next bit 0: down-counter reloads per match, interrupt when it expires.
// R5: Next bit 1: count matches, interrupt at programmed value, then restart.
// R6: Layer 2 select 01 type only, 10 address only, 11 both.
// R7: Layer 3 select 01 tests masked IP address or protocol.
// R8: Layer 3 select 10 compares source IP against destination IP.
// R9: Layer 4 select 00 protocol, 01 TCP ports, 10 UDP ports, 11 sequence.
// R10: Side select 0 uses destination fields, 1 uses source fields.
// R11: Equal sense 0 hits on inequality, 1 on equality.
// R12: Entries hold MAC, Ether type, IP address and IP mask.
// R13: Range mode: off, equals either bound, inside bounds, outside bounds.
// R14: TCP flags compared only while flag test is on.
// R15: Priority: QoS, level if greater, level if smaller, always level.
// R16: Remark replaces VLAN priority of tagged frames when enabled.
// R17: Map combine keeps, ORs, ANDs or replaces the lookup map.
// R18: Port map field has one forwarding bit per switch port.
// R19: Lead rule index names the entry whose action a group uses.
// R20: Group match is AND of all rules selected by its mask.
// R21: Matched groups are arbitrated by lowest lead index.
// R22: Host gets OR by giving several groups the same action.
// R23: Per port: filter enable plus pass, block or trap admission mode.
// R24: Missed frames: pass forwards, block drops, trap goes to CPU port.
// R25: One evaluation and at most one action per received frame.

`timescale 1ns/10ps

module acl_rule_filter (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          rst,
	// Byte register access
	input  wire logic [7:0]                    reg_addr,
	input  wire logic [7:0]                    reg_wdata,
	input  wire logic                          reg_we,
	input  wire logic                          reg_re,
	output logic [7:0]                         reg_rdata_ff,
	output logic                               reg_rvalid_ff,
	// Per-port admission control
	input  wire logic [acl_pkg::ACL_NPORT-1:0] port_filter_on,
	input  wire logic [2*acl_pkg::ACL_NPORT-1:0] port_adm_mode,
	// Received frame
	input  wire logic                          frame_valid,
	input  wire logic [2:0]                    frame_port,
	input  wire logic [47:0]                   frame_dst_mac,
	input  wire logic [47:0]                   frame_src_mac,
	input  wire logic [15:0]                   frame_ether_type,
	input  wire logic [31:0]                   frame_dst_ip,
	input  wire logic [31:0]                   frame_src_ip,
	input  wire logic [7:0]                    frame_ip_proto,
	input  wire logic                          frame_is_tcp,
	input  wire logic                          frame_is_udp,
	input  wire logic [15:0]                   frame_dst_l4,
	input  wire logic [15:0]                   frame_src_l4,
	input  wire logic [31:0]                   frame_tcp_seq,
	input  wire logic [5:0]                    frame_tcp_flags,
	input  wire logic                          frame_tagged,
	input  wire logic [2:0]                    frame_vlan_pri,
	input  wire logic [2:0]                    frame_qos_pri,
	input  wire logic [acl_pkg::ACL_NPORT-1:0] frame_lookup_map,
	// Frame decision
	output logic                               res_valid_ff,
	output logic                               res_hit_ff,
	output logic [3:0]                         res_rule_ff,
	output logic [acl_pkg::ACL_NPORT-1:0]      res_map_ff,
	output logic [2:0]                         res_pri_ff,
	output logic [2:0]                         res_vlan_pri_ff,
	// Rule timer events
	output logic [acl_pkg::ACL_NUM_RULES-1:0]  rule_irq_ff
);
	import acl_pkg::*;

	// ----------------------------------------------------------------
	// Rule table and indirect access
	// ----------------------------------------------------------------
	logic [7:0] tbl_ff [ACL_NUM_RULES*ACL_ENTRY_BYTES];
	logic [7:0] nxt_tbl [ACL_NUM_RULES*ACL_ENTRY_BYTES];
	logic [7:0] ctrl_hi_ff;
	logic [7:0] nxt_ctrl_hi;
	logic [7:0] ctrl_lo_ff;
	logic [7:0] nxt_ctrl_lo;
	logic [7:0] nxt_reg_rdata;
	logic       nxt_reg_rvalid;
	logic [7:0] win_idx;
	logic       win_ok;

	always_comb begin
		// Entry in high low nibble, byte in low low nibble
		win_idx = 8'(ctrl_hi_ff[3:0] * ACL_ENTRY_BYTES) + {4'h0, ctrl_lo_ff[3:0]};
		win_ok  = ctrl_lo_ff < 8'(ACL_ENTRY_BYTES);
		nxt_tbl        = tbl_ff;
		nxt_ctrl_hi    = ctrl_hi_ff;
		nxt_ctrl_lo    = ctrl_lo_ff;
		nxt_reg_rdata  = reg_rdata_ff;
		nxt_reg_rvalid = reg_re;
		if (reg_re) begin
			if (reg_addr == ACL_ADDR_CTRL_HI) begin
				nxt_reg_rdata = ctrl_hi_ff;
			end else if (reg_addr == ACL_ADDR_CTRL_LO) begin
				nxt_reg_rdata = ctrl_lo_ff;
			end else if (reg_addr == ACL_ADDR_WINDOW) begin
				nxt_reg_rdata = win_ok ? tbl_ff[win_idx] : 8'h00;
				// Auto-advance so an entry streams out in one burst
				nxt_ctrl_lo = ctrl_lo_ff + 8'h01;
			end else begin
				nxt_reg_rdata = 8'h00;
			end
		end else if (reg_we) begin
			if (reg_addr == ACL_ADDR_CTRL_HI) begin
				nxt_ctrl_hi = reg_wdata;
			end else if (reg_addr == ACL_ADDR_CTRL_LO) begin
				nxt_ctrl_lo = reg_wdata;
			end else if (reg_addr == ACL_ADDR_WINDOW) begin
				if (win_ok) begin
					nxt_tbl[win_idx] = reg_wdata;
				end
				nxt_ctrl_lo = ctrl_lo_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < ACL_NUM_RULES * ACL_ENTRY_BYTES; i++) begin
				tbl_ff[i] <= 8'h00;
			end
			ctrl_hi_ff    <= ACL_CTRL_RST;
			ctrl_lo_ff    <= ACL_CTRL_RST;
			reg_rdata_ff  <= 8'h00;
			reg_rvalid_ff <= 1'b0;
		end else begin
			tbl_ff        <= nxt_tbl;
			ctrl_hi_ff    <= nxt_ctrl_hi;
			ctrl_lo_ff    <= nxt_ctrl_lo;
			reg_rdata_ff  <= nxt_reg_rdata;
			reg_rvalid_ff <= nxt_reg_rvalid;
		end
	end

	// ----------------------------------------------------------------
	// Per-rule match
	// ----------------------------------------------------------------
	logic [ACL_ENTRY_W-1:0]   ent [ACL_NUM_RULES];
	logic [ACL_NUM_RULES-1:0] rule_hit;

	always_comb begin
		for (int r = 0; r < ACL_NUM_RULES; r++) begin
			for (int b = 0; b < ACL_ENTRY_BYTES; b++) begin
				ent[r][b*8 +: 8] = tbl_ff[r*ACL_ENTRY_BYTES + b]; // R12
			end
		end
	end

	for (genvar g = 0; g < ACL_NUM_RULES; g++) begin : g_rule
		acl_rule_match u_match (
			.rule_kind   (ent[g][ACL_KIND_LSB +: 2]),
			.test_select (ent[g][ACL_TSEL_LSB +: 2]),
			.side_select (ent[g][ACL_SIDE_BIT]),
			.equal_sense (ent[g][ACL_EQ_BIT]),
			.match_area  (ent[g][ACL_MATCH_LSB +: ACL_MATCH_W]),
			.dst_mac     (frame_dst_mac),
			.src_mac     (frame_src_mac),
			.ether_type  (frame_ether_type),
			.dst_ip      (frame_dst_ip),
			.src_ip      (frame_src_ip),
			.ip_proto    (frame_ip_proto),
			.is_tcp      (frame_is_tcp),
			.is_udp      (frame_is_udp),
			.dst_l4      (frame_dst_l4),
			.src_l4      (frame_src_l4),
			.tcp_seq     (frame_tcp_seq),
			.tcp_flags   (frame_tcp_flags),
			.hit         (rule_hit[g])
		);
	end

	// ----------------------------------------------------------------
	// Group arbitration and action
	// ----------------------------------------------------------------
	logic [ACL_NUM_RULES-1:0] grp_mask;
	logic                     found;
	logic [3:0]               best;
	logic [3:0]               lead;
	logic [ACL_ENTRY_W-1:0]   act;
	logic [2:0]               lvl;
	logic [4:0]               pmap;
	logic [1:0]               adm;
	logic                     filt_on;
	logic                     nxt_res_valid;
	logic                     nxt_res_hit;
	logic [3:0]               nxt_res_rule;
	logic [ACL_NPORT-1:0]     nxt_res_map;
	logic [2:0]               nxt_res_pri;
	logic [2:0]               nxt_res_vlan_pri;

	always_comb begin
		found = 1'b0;
		best  = 4'h0;
		for (int g = 0; g < ACL_NUM_RULES; g++) begin
			grp_mask = ent[g][ACL_GRP_LSB +: ACL_NUM_RULES];
			lead     = ent[g][ACL_LEAD_LSB +: 4];
			// Empty mask or disabled owner means the group is unused
			if ((ent[g][ACL_KIND_LSB +: 2] != ACL_KIND_OFF) && (grp_mask != 16'h0000) &&
				((rule_hit & grp_mask) == grp_mask)) begin // R20
				if (!found || (lead < best)) begin // R21
					found = 1'b1;
					best  = lead;
				end
			end
		end
		grp_mask = 16'h0000;
		lead     = 4'h0;
		act      = ent[best]; // R19
		lvl      = act[ACL_LVL_LSB +: 3];
		pmap     = act[ACL_MAP_LSB +: ACL_NPORT]; // R18
		adm      = port_adm_mode[2*frame_port +: 2];
		filt_on  = port_filter_on[frame_port]; // R23
		nxt_res_valid    = frame_valid; // R25
		nxt_res_hit      = res_hit_ff;
		nxt_res_rule     = res_rule_ff;
		nxt_res_map      = res_map_ff;
		nxt_res_pri      = res_pri_ff;
		nxt_res_vlan_pri = res_vlan_pri_ff;
		if (frame_valid) begin
			nxt_res_hit      = filt_on && found;
			nxt_res_rule     = best;
			nxt_res_map      = frame_lookup_map;
			nxt_res_pri      = frame_qos_pri;
			nxt_res_vlan_pri = frame_vlan_pri;
			if (filt_on && found) begin
				case (act[ACL_OVR_LSB +: 2]) // R15
					ACL_SEL_0: nxt_res_pri = frame_qos_pri;
					ACL_SEL_1: nxt_res_pri = (lvl > frame_qos_pri) ? lvl : frame_qos_pri;
					ACL_SEL_2: nxt_res_pri = (lvl < frame_qos_pri) ? lvl : frame_qos_pri;
					default:   nxt_res_pri = lvl;
				endcase
				if (act[ACL_RPE_BIT] && frame_tagged) begin
					nxt_res_vlan_pri = act[ACL_RPV_LSB +: 3]; // R16
				end
				case (act[ACL_MM_LSB +: 2]) // R17
					ACL_SEL_0: nxt_res_map = frame_lookup_map;
					ACL_SEL_1: nxt_res_map = frame_lookup_map | pmap;
					ACL_SEL_2: nxt_res_map = frame_lookup_map & pmap;
					default:   nxt_res_map = pmap;
				endcase
			end else if (filt_on) begin
				// Undefined admission code behaves as pass
				if (adm == ACL_ADM_BLOCK) begin
					nxt_res_map = 5'h00; // R24
				end else if (adm == ACL_ADM_TRAP) begin
					nxt_res_map = ACL_CPU_MAP; // R24
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			res_valid_ff    <= 1'b0;
			res_hit_ff      <= 1'b0;
			res_rule_ff     <= 4'h0;
			res_map_ff      <= 5'h00;
			res_pri_ff      <= 3'h0;
			res_vlan_pri_ff <= 3'h0;
		end else begin
			res_valid_ff    <= nxt_res_valid;
			res_hit_ff      <= nxt_res_hit;
			res_rule_ff     <= nxt_res_rule;
			res_map_ff      <= nxt_res_map;
			res_pri_ff      <= nxt_res_pri;
			res_vlan_pri_ff <= nxt_res_vlan_pri;
		end
	end

	// ----------------------------------------------------------------
	// Time base and per-rule timers
	// ----------------------------------------------------------------
	logic [5:0]               us_cnt_ff;
	logic [5:0]               nxt_us_cnt;
	logic [9:0]               ms_cnt_ff;
	logic [9:0]               nxt_ms_cnt;
	logic                     us_tick;
	logic                     ms_tick;
	logic [ACL_CNT_W-1:0]     cnt_ff [ACL_NUM_RULES];
	logic [ACL_CNT_W-1:0]     nxt_cnt [ACL_NUM_RULES];
	logic [ACL_NUM_RULES-1:0] armed_ff;
	logic [ACL_NUM_RULES-1:0] nxt_armed;
	logic [ACL_NUM_RULES-1:0] nxt_irq;
	logic [ACL_CNT_W-1:0]     cval;
	logic                     tick;
	logic                     hitp;

	always_comb begin
		us_tick    = us_cnt_ff == ACL_US_LAST;
		ms_tick    = us_tick && (ms_cnt_ff == ACL_MS_LAST);
		nxt_us_cnt = us_tick ? 6'h00 : us_cnt_ff + 6'h01;
		nxt_ms_cnt = ms_cnt_ff;
		if (us_tick) begin
			nxt_ms_cnt = (ms_cnt_ff == ACL_MS_LAST) ? 10'h000 : ms_cnt_ff + 10'h001;
		end
		cval = 11'h000;
		tick = 1'b0;
		hitp = 1'b0;
		for (int r = 0; r < ACL_NUM_RULES; r++) begin
			cval         = ent[r][ACL_CNT_LSB +: ACL_CNT_W]; // R2
			tick         = ent[r][ACL_UNIT_BIT] ? ms_tick : us_tick; // R3
			hitp         = frame_valid && rule_hit[r];
			nxt_cnt[r]   = cnt_ff[r];
			nxt_armed[r] = armed_ff[r];
			nxt_irq[r]   = 1'b0;
			if ((ent[r][ACL_KIND_LSB +: 2] != ACL_KIND_L2) ||
				(ent[r][ACL_TSEL_LSB +: 2] != ACL_SEL_0)) begin
				nxt_cnt[r]   = 11'h000;
				nxt_armed[r] = 1'b0;
			end else if (ent[r][ACL_ALGO_BIT]) begin
				nxt_armed[r] = 1'b0;
				if (hitp) begin // R5
					if (cnt_ff[r] + 11'h001 == cval) begin
						nxt_irq[r] = 1'b1;
						nxt_cnt[r] = 11'h000;
					end else begin
						nxt_cnt[r] = cnt_ff[r] + 11'h001;
					end
				end
			end else if (hitp) begin
				// A fresh match restarts the quiet-period watch
				nxt_cnt[r]   = cval; // R4
				nxt_armed[r] = cval != 11'h000;
			end else if (armed_ff[r] && tick) begin
				if (cnt_ff[r] == 11'h001) begin
					nxt_irq[r]   = 1'b1; // R4
					nxt_armed[r] = 1'b0;
					nxt_cnt[r]   = 11'h000;
				end else begin
					nxt_cnt[r] = cnt_ff[r] - 11'h001;
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			us_cnt_ff   <= 6'h00;
			ms_cnt_ff   <= 10'h000;
			armed_ff    <= 16'h0000;
			rule_irq_ff <= 16'h0000;
			for (int r = 0; r < ACL_NUM_RULES; r++) begin
				cnt_ff[r] <= 11'h000;
			end
		end else begin
			us_cnt_ff   <= nxt_us_cnt;
			ms_cnt_ff   <= nxt_ms_cnt;
			armed_ff    <= nxt_armed;
			rule_irq_ff <= nxt_irq;
			for (int r = 0; r < ACL_NUM_RULES; r++) begin
				cnt_ff[r] <= nxt_cnt[r];
			end
		end
	end

endmodule : acl_rule_filter

/* hw/acl_pkg.sv */
// Purpose: Shared constants for the ingress rule filter
// Assumes: 16-entry rule table, five switch ports, 50 MHz core clock
// Notes:   Entry bytes are packed little-endian into one flat entry vector

package acl_pkg;

	// ----------------------------------------------------------------
	// Table geometry
	// ----------------------------------------------------------------
	localparam int ACL_NUM_RULES   = 16;
	localparam int ACL_ENTRY_BYTES = 15;
	localparam int ACL_ENTRY_W     = ACL_ENTRY_BYTES * 8;
	localparam int ACL_NPORT       = 5;
	localparam int ACL_MATCH_W     = 72;

	// ----------------------------------------------------------------
	// Byte register addresses and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ACL_ADDR_CTRL_HI = 8'h6e;
	localparam logic [7:0] ACL_ADDR_CTRL_LO = 8'h6f;
	localparam logic [7:0] ACL_ADDR_WINDOW  = 8'ha0;
	localparam logic [7:0] ACL_CTRL_RST     = 8'h00;

	// ----------------------------------------------------------------
	// Entry vector field positions
	// ----------------------------------------------------------------
	localparam int ACL_KIND_LSB  = 0;
	localparam int ACL_TSEL_LSB  = 2;
	localparam int ACL_SIDE_BIT  = 4;
	localparam int ACL_EQ_BIT    = 5;
	localparam int ACL_MATCH_LSB = 8;
	localparam int ACL_CNT_LSB   = 80;
	localparam int ACL_CNT_W     = 11;
	localparam int ACL_MM_LSB    = 80;
	localparam int ACL_RPV_LSB   = 82;
	localparam int ACL_RPE_BIT   = 85;
	localparam int ACL_LVL_LSB   = 86;
	localparam int ACL_OVR_LSB   = 89;
	localparam int ACL_MAP_LSB   = 91;
	localparam int ACL_UNIT_BIT  = 95;
	localparam int ACL_ALGO_BIT  = 94;
	localparam int ACL_LEAD_LSB  = 96;
	localparam int ACL_GRP_LSB   = 104;

	// Match area sub-fields
	localparam int ACL_M_MAC_LSB  = 0;
	localparam int ACL_M_TYPE_LSB = 48;
	localparam int ACL_M_IP_LSB   = 0;
	localparam int ACL_M_MASK_LSB = 32;
	localparam int ACL_M_L3PR_LSB = 64;
	localparam int ACL_M_UPR_LSB  = 0;
	localparam int ACL_M_LWR_LSB  = 16;
	localparam int ACL_M_SEQ_LSB  = 0;
	localparam int ACL_M_PC_LSB   = 32;
	localparam int ACL_M_PRO_LSB  = 34;
	localparam int ACL_M_FTO_BIT  = 42;
	localparam int ACL_M_CARE_LSB = 43;
	localparam int ACL_M_WANT_LSB = 49;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] ACL_KIND_OFF = 2'h0;
	localparam logic [1:0] ACL_KIND_L2  = 2'h1;
	localparam logic [1:0] ACL_KIND_L3  = 2'h2;
	localparam logic [1:0] ACL_KIND_L4  = 2'h3;
	localparam logic [1:0] ACL_SEL_0    = 2'h0;
	localparam logic [1:0] ACL_SEL_1    = 2'h1;
	localparam logic [1:0] ACL_SEL_2    = 2'h2;
	localparam logic [1:0] ACL_SEL_3    = 2'h3;
	localparam logic [1:0] ACL_ADM_PASS  = 2'h0;
	localparam logic [1:0] ACL_ADM_BLOCK = 2'h1;
	localparam logic [1:0] ACL_ADM_TRAP  = 2'h3;
	localparam logic [4:0] ACL_CPU_MAP   = 5'h10;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int ACL_CLK_NS    = 20;
	localparam int ACL_US_NS     = 1000;
	localparam int ACL_US_CYCLES = (ACL_US_NS + ACL_CLK_NS - 1) / ACL_CLK_NS;
	localparam int ACL_MS_US     = 1000;
	localparam logic [5:0] ACL_US_LAST = 6'(ACL_US_CYCLES - 1);
	localparam logic [9:0] ACL_MS_LAST = 10'(ACL_MS_US - 1);

endpackage : acl_pkg

/* hw/acl_rule_match.sv */
// Purpose: Combinational test of one frame against one rule entry
// Assumes: Frame fields are stable while the result is sampled
// Notes:   Disabled or undefined selections never hit

`timescale 1ns/10ps

module acl_rule_match (
	// Rule fields
	input  wire logic [1:0]  rule_kind,
	input  wire logic [1:0]  test_select,
	input  wire logic        side_select,
	input  wire logic        equal_sense,
	input  wire logic [71:0] match_area,
	// Frame fields
	input  wire logic [47:0] dst_mac,
	input  wire logic [47:0] src_mac,
	input  wire logic [15:0] ether_type,
	input  wire logic [31:0] dst_ip,
	input  wire logic [31:0] src_ip,
	input  wire logic [7:0]  ip_proto,
	input  wire logic        is_tcp,
	input  wire logic        is_udp,
	input  wire logic [15:0] dst_l4,
	input  wire logic [15:0] src_l4,
	input  wire logic [31:0] tcp_seq,
	input  wire logic [5:0]  tcp_flags,
	// Result
	output logic             hit
);
	import acl_pkg::*;

	logic [47:0] sel_mac;
	logic [31:0] sel_ip;
	logic [15:0] sel_l4;
	logic [15:0] upper_bound;
	logic [15:0] lower_bound;
	logic [31:0] ip_mask;
	logic [5:0]  tcp_bits_care;
	logic [5:0]  tcp_bits_wanted;
	logic        mac_eq;
	logic        type_eq;
	logic        proto_eq;
	logic        port_ok;
	logic        flag_ok;
	logic        cmp;
	logic        valid;

	always_comb begin
		sel_mac         = side_select ? src_mac : dst_mac; // R10
		sel_ip          = side_select ? src_ip : dst_ip; // R10
		sel_l4          = side_select ? src_l4 : dst_l4; // R10
		upper_bound     = match_area[ACL_M_UPR_LSB +: 16];
		lower_bound     = match_area[ACL_M_LWR_LSB +: 16];
		ip_mask         = match_area[ACL_M_MASK_LSB +: 32];
		tcp_bits_care   = match_area[ACL_M_CARE_LSB +: 6];
		tcp_bits_wanted = match_area[ACL_M_WANT_LSB +: 6];
		mac_eq   = sel_mac == match_area[ACL_M_MAC_LSB +: 48]; // R12
		type_eq  = ether_type == match_area[ACL_M_TYPE_LSB +: 16]; // R12
		proto_eq = ip_proto == match_area[ACL_M_PRO_LSB +: 8];
		case (match_area[ACL_M_PC_LSB +: 2]) // R13
			ACL_SEL_0: port_ok = 1'b1;
			ACL_SEL_1: port_ok = (sel_l4 == upper_bound) || (sel_l4 == lower_bound);
			ACL_SEL_2: port_ok = (sel_l4 >= lower_bound) && (sel_l4 <= upper_bound);
			default:   port_ok = (sel_l4 < lower_bound) || (sel_l4 > upper_bound);
		endcase
		// Only the cared-for flag bits take part
		flag_ok = !match_area[ACL_M_FTO_BIT] ||
			((tcp_flags & tcp_bits_care) == (tcp_bits_wanted & tcp_bits_care)); // R14
		cmp   = 1'b0;
		valid = 1'b1;
		case (rule_kind) // R1
			ACL_KIND_L2: begin
				case (test_select) // R6
					ACL_SEL_1: cmp = type_eq;
					ACL_SEL_2: cmp = mac_eq;
					default:   cmp = mac_eq && type_eq;
				endcase
			end
			ACL_KIND_L3: begin
				if (test_select == ACL_SEL_1) begin // R7
					// Zero mask selects the protocol test instead
					if (ip_mask != 32'h0000_0000) begin
						cmp = (sel_ip & ip_mask) ==
							(match_area[ACL_M_IP_LSB +: 32] & ip_mask);
					end else begin
						cmp = ip_proto == match_area[ACL_M_L3PR_LSB +: 8];
					end
				end else if (test_select == ACL_SEL_2) begin
					cmp = src_ip == dst_ip; // R8
				end else begin
					valid = 1'b0;
				end
			end
			ACL_KIND_L4: begin
				case (test_select) // R9
					ACL_SEL_0: cmp = proto_eq;
					ACL_SEL_1: cmp = is_tcp && port_ok && flag_ok;
					ACL_SEL_2: cmp = is_udp && port_ok;
					default:   cmp = is_tcp && flag_ok &&
						(tcp_seq == match_area[ACL_M_SEQ_LSB +: 32]);
				endcase
			end
			default: valid = 1'b0;
		endcase
		hit = valid && (equal_sense ? cmp : !cmp); // R11
	end

endmodule : acl_rule_match

/* verif/acl_lkp_model.sv */
// Purpose: Lookup datapath stand-in feeding forwarding map and QoS
// Assumes: Ingress port index 0..4
// Notes:   Floods all ports but the ingress one; QoS follows the port

`timescale 1ns/10ps

module acl_lkp_model
	import acl_pkg::*;
(
	// Frame side
	input  wire logic [2:0]                    frame_port,
	output logic      [acl_pkg::ACL_NPORT-1:0] lookup_map,
	output logic      [2:0]                    qos_pri
);
	always_comb begin
		lookup_map = ~(5'h01 << frame_port);
		qos_pri    = frame_port + 3'h1;
	end
endmodule : acl_lkp_model

/* verif/acl_filter_asserts.sv */
// Purpose: Port-level properties of the ingress rule filter
// Assumes: Frame port index stays within 0..4
// Notes:   Bound to every filter instance

`timescale 1ns/10ps

module acl_filter_asserts
	import acl_pkg::*;
(
	// Clock, reset, register answer
	input wire logic                            clock,
	input wire logic                            rst,
	input wire logic                            reg_re,
	input wire logic                            reg_rvalid_ff,
	// Frame in
	input wire logic [acl_pkg::ACL_NPORT-1:0]   port_filter_on,
	input wire logic [2*acl_pkg::ACL_NPORT-1:0] port_adm_mode,
	input wire logic                            frame_valid,
	input wire logic [2:0]                      frame_port,
	input wire logic                            frame_tagged,
	input wire logic [2:0]                      frame_vlan_pri,
	input wire logic [2:0]                      frame_qos_pri,
	input wire logic [acl_pkg::ACL_NPORT-1:0]   frame_lookup_map,
	// Decision
	input wire logic                            res_valid_ff,
	input wire logic                            res_hit_ff,
	input wire logic [acl_pkg::ACL_NPORT-1:0]   res_map_ff,
	input wire logic [2:0]                      res_pri_ff,
	input wire logic [2:0]                      res_vlan_pri_ff
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence f_on_s; frame_valid && port_filter_on[frame_port]; endsequence
	sequence f_off_s; frame_valid && !port_filter_on[frame_port]; endsequence
	sequence blk_s; f_on_s ##0 (port_adm_mode[2*frame_port +: 2] == ACL_ADM_BLOCK); endsequence
	sequence trp_s; f_on_s ##0 (port_adm_mode[2*frame_port +: 2] == ACL_ADM_TRAP); endsequence

	res_once_a: assert property (frame_valid |=> res_valid_ff)
		else $error("no result after frame");
	res_only_a: assert property (!frame_valid |=> !res_valid_ff)
		else $error("result without frame");
	res_hold_a: assert property (!frame_valid |=> $stable(res_map_ff) && $stable(res_pri_ff))
		else $error("result changed between frames");
	off_pass_a: assert property (f_off_s |=> !res_hit_ff && res_map_ff == $past(frame_lookup_map))
		else $error("disabled port altered map");
	off_qos_a: assert property (f_off_s |=> res_pri_ff == $past(frame_qos_pri))
		else $error("disabled port altered priority");
	block_miss_a: assert property (blk_s |=> res_hit_ff || res_map_ff == '0)
		else $error("blocked miss forwarded");
	trap_miss_a: assert property (trp_s |=> res_hit_ff || res_map_ff == ACL_CPU_MAP)
		else $error("trapped miss not sent to cpu");
	untag_keep_a: assert property (frame_valid && !frame_tagged |=>
		res_vlan_pri_ff == $past(frame_vlan_pri))
		else $error("untagged frame remarked");
	rd_answer_a: assert property (reg_re |=> reg_rvalid_ff)
		else $error("read not answered");
endmodule : acl_filter_asserts

bind acl_rule_filter acl_filter_asserts i_chk (.clock, .rst, .reg_re, .reg_rvalid_ff,
	.port_filter_on, .port_adm_mode, .frame_valid, .frame_port, .frame_tagged, .frame_vlan_pri,
	.frame_qos_pri, .frame_lookup_map, .res_valid_ff, .res_hit_ff, .res_map_ff, .res_pri_ff,
	.res_vlan_pri_ff);

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the ingress rule filter
// Assumes: Lookup model gives map and QoS per port
// Notes:   Groups race on lead index; one rule counts

`timescale 1ns/10ps

module tb_top;
	import acl_pkg::*;
	logic        clock = 0, rst = 1, reg_we = 0, reg_re = 0, fv = 0, tag = 0, rv, hit, rvld;
	logic [7:0]  reg_addr = 0, reg_wdata = 0, rdata;
	logic [4:0]  fon = 0, lmap, map;
	logic [9:0]  adm = 0;
	logic [2:0]  fport = 0, vpri = 0, qos, pri, vout;
	logic [47:0] dmac = 0, smac = 0;
	logic [31:0] r = 32'h0001_16fe, ip = 0;
	logic [15:0] l4 = 0, irq;
	logic [5:0]  flags = 0;
	logic [3:0]  rule, win = 4'h2;
	int          err_count = 0, total_checks = 0, cyc = 0, nm = 0;
	localparam logic [47:0] MAC = 48'h0a1b_2c3d_4e5f;
	always #10 clock = ~clock;

	acl_lkp_model i_lkp (.frame_port(fport), .lookup_map(lmap), .qos_pri(qos));
	acl_rule_filter i_dut (.clock, .rst, .reg_addr, .reg_wdata,
		.reg_we, .reg_re, .reg_rdata_ff(rdata), .reg_rvalid_ff(rvld),
		.port_filter_on(fon), .port_adm_mode(adm), .frame_valid(fv), .frame_port(fport),
		.frame_dst_mac(dmac), .frame_src_mac(smac), .frame_ether_type(l4), .frame_dst_ip(ip),
		.frame_src_ip(~ip), .frame_ip_proto(ip[7:0]), .frame_is_tcp(tag), .frame_is_udp(~tag),
		.frame_dst_l4(l4), .frame_src_l4(ip[15:0]), .frame_tcp_seq(ip), .frame_tcp_flags(flags),
		.frame_tagged(tag), .frame_vlan_pri(vpri), .frame_qos_pri(qos), .frame_lookup_map(lmap),
		.res_valid_ff(rv), .res_hit_ff(hit), .res_rule_ff(rule), .res_map_ff(map),
		.res_pri_ff(pri), .res_vlan_pri_ff(vout), .rule_irq_ff(irq));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [4:0] lk(input logic [2:0] p);
		return ~(5'h01 << p);
	endfunction : lk
	task automatic chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		@(posedge clock);
		reg_we    <= 1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_we <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_re   <= 1;
		reg_addr <= a;
		@(posedge clock);
		reg_re <= 0;
		#1;
	endtask : rd
	// Entry e: low bits k, action a, own group
	task automatic put(input logic [3:0] e, input logic [5:0] k, input logic [15:0] a);
		logic [119:0] v;
		v          = '0;
		v[5:0]     = k;
		v[55:8]    = MAC;
		v[95:80]   = a;
		v[99:96]   = e;
		v[119:104] = 16'h0001 << e;
		wr(ACL_ADDR_CTRL_HI, {4'h0, e});
		wr(ACL_ADDR_CTRL_LO, 8'h00);
		for (int i = 0; i < ACL_ENTRY_BYTES; i++) wr(ACL_ADDR_WINDOW, v[8*i +: 8]);
	endtask : put
	task automatic frm(input logic [2:0] p, input logic m);
		logic       e;
		logic [1:0] md;
		@(posedge clock);
		r = lfsr(r);
		fv    <= 1;
		fport <= p;
		dmac  <= m ? MAC : MAC ^ {r, 16'h0001};
		smac  <= MAC;
		ip    <= r;
		l4    <= m ? '0 : r[31:16];
		flags <= r[5:0];
		tag   <= r[6];
		vpri  <= r[9:7];
		fon   <= r[14:10];
		adm   <= r[24:15];
		@(posedge clock);
		fv <= 0;
		#1;
		e  = fon[p] && m;
		md = adm[2*p +: 2];
		chk(rv, 1);
		chk(hit, e);
		chk(map, e ? 5'h05 : (!fon[p] || !md[0]) ? lk(p) : md[1] ? ACL_CPU_MAP : 5'h00);
		chk(pri, e ? 3'h5 : p + 3'h1);
		chk(vout, (e && tag) ? 3'h6 : vpri);
		if (e) chk(rule, win);
		nm += m;
		chk(irq, 16'(m && nm % 5 == 0) << 3);
	endtask : frm
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done

	// Hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			test_done;
		end
	end

	initial begin
		repeat (12) @(posedge clock);
		rst <= 0;
		rd(ACL_ADDR_CTRL_HI);
		chk({rvld, rdata}, {1'b1, ACL_CTRL_RST});
		rd(8'h55);
		chk({rvld, rdata}, 9'h100);
		put(4'h2, 6'h29, 16'h2f7b);
		put(4'h3, 6'h21, 16'h4005);
		wr(ACL_ADDR_CTRL_HI, 8'h02);
		wr(ACL_ADDR_CTRL_LO, 8'h0d);
		rd(ACL_ADDR_WINDOW);
		chk({rvld, rdata}, 9'h104);
		rd(ACL_ADDR_WINDOW);
		chk({rvld, rdata}, 9'h100);
		rd(ACL_ADDR_CTRL_LO);
		chk({rvld, rdata}, 9'h10f);
		for (int i = 0; i < 40; i++) frm(3'(r % 5), r[20]);
		put(4'h1, 6'h29, 16'h2f7b);
		win  = 4'h1;
		for (int i = 0; i < 40; i++) frm(3'(r % 5), r[20]);
		test_done;
	end
endmodule : tb_top
